// ---- rtl/evc_map.svh ----
`ifndef EVC_MAP_SVH
`define EVC_MAP_SVH

// Register byte offsets on the Avalon-MM slave
`define EVC_OFF_CTRL_A 8'h00
`define EVC_OFF_CTRL_B 8'h04
`define EVC_OFF_DATA_A 8'h08
`define EVC_OFF_DATA_B 8'h0c
`define EVC_OFF_STATUS 8'h10
`define EVC_OFF_MASK 8'h14

// Control register field positions
`define EVC_MODE_HI 7
`define EVC_MODE_LO 6
`define EVC_SRC_BIT 5
`define EVC_RUN_BIT 4
`define EVC_EDGE_BIT 3
`define EVC_DIV_HI 2
`define EVC_DIV_LO 0

// Status and mask bit positions
`define EVC_IRQ_A_BIT 0
`define EVC_IRQ_B_BIT 1

// Reset values
`define EVC_CTRL_RST 8'h08
`define EVC_PRE_RST 8'h00
`define EVC_CNT_RST 8'h00
`define EVC_IRQ_RST 2'h0
`define EVC_RDATA_RST 32'h0000_0000

// Counter and divider limits
`define EVC_CNT_MAX 8'hff
`define EVC_DIV_ALL 7'h7f
`define EVC_DIV_ONE 7'h01

`endif

// ---- rtl/evc_pkg.sv ----
package evc_pkg;

    // Operating modes in mode field encoding order
    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_EVENT,
        MODE_TIMER,
        MODE_PWM
    } mode_t;

    // State of one counter channel
    typedef struct packed {
        logic [6:0] div;     // Free prescaler tick counter
        logic [7:0] count;   // Live counter value
        logic prev;          // Source level last cycle
        logic meas;          // Pulse width window open
        logic ovf;           // Overflow pulse
    } core_state_t;

    // State of the two-stage pin synchroniser
    typedef struct packed {
        logic [1:0] s1;      // First stage
        logic [1:0] s2;      // Second stage
    } sync_state_t;

    // State of the register and bus block
    typedef struct packed {
        logic [7:0] ctrl_a;  // Counter A control
        logic [7:0] ctrl_b;  // Counter B control
        logic [7:0] pre_a;   // Counter A preload
        logic [7:0] pre_b;   // Counter B preload
        logic [1:0] status;  // Sticky overflow flags
        logic [1:0] mask;    // Interrupt enables
        logic waitreq;       // Avalon waitrequest
        logic [31:0] rdata;  // Avalon read data
        logic irq;           // Interrupt output
    } top_state_t;

endpackage : evc_pkg

// ---- rtl/evc_sync2.sv ----
module evc_sync2 (
    input wire logic clk_sys_i,      // System clock
    input wire logic rstn_i,         // Synchronous reset, active low
    input wire logic [1:0] async_i,  // Pin levels
    output logic [1:0] sync_o        // Synchronised levels
);

    evc_pkg::sync_state_t st_r;   // Registered state
    evc_pkg::sync_state_t st_nxt; // Next state

    // Second stage only reads the first
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = async_i;
        st_nxt.s2 = st_r.s1;
    end

    // Register the state
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign sync_o = st_r.s2;

endmodule : evc_sync2

// ---- rtl/evc_core.sv ----
`include "evc_map.svh"

module evc_core (
    input wire logic clk_sys_i,       // System clock
    input wire logic rstn_i,          // Synchronous reset, active low
    input wire logic [1:0] mode_i,    // Mode field
    input wire logic run_i,           // Run bit
    input wire logic edge_i,          // Edge select bit
    input wire logic [2:0] div_i,     // Divider field
    input wire logic pulse_src_i,     // Source is a pulse signal
    input wire logic src_i,           // Selected external source
    input wire logic psc_tick_i,      // Prescaler clock tick
    input wire logic [7:0] preload_i, // Preload value
    input wire logic load_i,          // Preload write strobe
    input wire logic [7:0] load_val_i, // Value being written
    output logic [7:0] count_o,       // Counter value
    output logic ovf_o                // Overflow pulse
);

    evc_pkg::core_state_t st_r;   // Registered state
    evc_pkg::core_state_t st_nxt; // Next state
    evc_pkg::mode_t mode;         // Decoded mode
    logic rise;                   // Source rising edge
    logic fall;                   // Source falling edge
    logic [6:0] lim;              // Divider tick mask
    logic div_tick;               // Divided internal clock
    logic start;                  // Measurement opens
    logic stop;                   // Measurement closes
    logic inc;                    // Count this cycle

    // Edges, divider and count decision
    always_comb
    begin
        st_nxt = st_r;
        mode = evc_pkg::mode_t'(mode_i);
        rise = src_i & ~st_r.prev;
        fall = ~src_i & st_r.prev;
        lim = (`EVC_DIV_ONE << div_i) - `EVC_DIV_ONE;
        div_tick = psc_tick_i & ((st_r.div & lim) == lim);
        start = edge_i ? rise : fall;
        stop = edge_i ? fall : rise;
        inc = 1'b0;
        st_nxt.prev = src_i;
        st_nxt.ovf = 1'b0;
        if (psc_tick_i)
        begin
            st_nxt.div = st_r.div + `EVC_DIV_ONE;
        end
        case (mode)
            // External edges, prescaler unused
            evc_pkg::MODE_EVENT:
            begin
                if (pulse_src_i)
                begin
                    inc = run_i & rise;
                end
                else
                begin
                    inc = run_i & (edge_i ? fall : rise);
                end
            end
            // Divided internal clock
            evc_pkg::MODE_TIMER:
            begin
                inc = run_i & div_tick;
            end
            // Internal clock gated by source window
            evc_pkg::MODE_PWM:
            begin
                if (!run_i)
                begin
                    st_nxt.meas = 1'b0;
                end
                else if (start)
                begin
                    st_nxt.meas = 1'b1;
                end
                else if (stop)
                begin
                    st_nxt.meas = 1'b0;
                end
                inc = run_i & st_r.meas & div_tick;
            end
            // Code 00 never counts
            default:
            begin
                st_nxt.meas = 1'b0;
            end
        endcase
        if (load_i && !run_i)
        begin
            st_nxt.count = load_val_i;
        end
        else if (inc)
        begin
            if (st_r.count == `EVC_CNT_MAX)
            begin
                st_nxt.count = preload_i;
                st_nxt.ovf = 1'b1;
            end
            else
            begin
                st_nxt.count = st_r.count + 8'h01;
            end
        end
    end

    // Register the state
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign count_o = st_r.count;
    assign ovf_o = st_r.ovf;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // Mode 00 and a stopped counter hold still
    a_idle_holds: assert property (
        (mode_i == 2'h0 || !run_i) && !load_i |=> $stable(st_r.count))
        else $error("counter moved while idle");
    // Run bit gates counting
    a_stop_holds: assert property (
        !run_i && !load_i |=> $stable(st_r.count))
        else $error("counter moved while stopped");
    // Undivided timer counts each prescaler tick
    a_timer_tick: assert property (
        mode_i == 2'h2 && run_i && div_i == 3'h0 && psc_tick_i
        && st_r.count != `EVC_CNT_MAX
        |=> st_r.count == $past(st_r.count) + 8'h01)
        else $error("timer missed a tick");
    // Event edge counts whatever the divider
    a_event_edge: assert property (
        mode_i == 2'h1 && run_i && !pulse_src_i && !load_i
        && (edge_i ? fall : rise) && st_r.count != `EVC_CNT_MAX
        |=> st_r.count == $past(st_r.count) + 8'h01)
        else $error("event edge not counted");
    // Pulse source counts on every pulse
    a_pulse_count: assert property (
        mode_i == 2'h1 && run_i && pulse_src_i && rise && !load_i
        && st_r.count != `EVC_CNT_MAX
        |=> st_r.count == $past(st_r.count) + 8'h01)
        else $error("pulse not counted");
    // Closed window never counts
    a_pwm_window: assert property (
        mode_i == 2'h3 && !st_r.meas && !load_i
        |=> $stable(st_r.count))
        else $error("pulse width counted outside window");
    // Overflow reloads and flags
    a_wrap_reload: assert property (
        inc && st_r.count == `EVC_CNT_MAX && !(load_i && !run_i)
        |=> st_r.count == $past(preload_i) && st_r.ovf)
        else $error("overflow did not reload");
    // Stopped preload write loads at once
    a_stopped_load: assert property (
        load_i && !run_i |=> st_r.count == $past(load_val_i))
        else $error("stopped preload not loaded");

    c_overflow: cover property (st_r.ovf);
    c_pwm_open: cover property (st_r.meas ##1 !st_r.meas);

endmodule : evc_core

// ---- rtl/event_counter_control.sv ----
// Contract
// - Counter A mode: 01 event, 10 timer, 11 width
// - Counter B mode uses same encoding
// - Run bit high counts, low stops
// - Divider field divides prescaler clock by 2^n
// - External source ignores divider setting
// - Event mode: edge 0 rising, 1 falling
// - Width mode edge 0: falling starts, rising stops
// - Counter A source: pin or comparator debounced
// - Counter B source: pin or comparator pulse
// - Pulse source in event mode ignores edge
// - Count to FFH, flag, reload, continue
// - Stopped preload loads now, running at overflow
`include "evc_map.svh"

module event_counter_control (
    input wire logic clk_sys_i,         // System clock, 10 MHz
    input wire logic rstn_i,            // Synchronous reset, active low
    input wire logic [7:0] address_i,   // Avalon byte address
    input wire logic read_i,            // Avalon read
    input wire logic write_i,           // Avalon write
    input wire logic [31:0] writedata_i, // Avalon write data
    input wire logic [3:0] byteenable_i, // Avalon byte enables
    output logic [31:0] readdata_o,     // Avalon read data
    output logic waitrequest_o,         // Avalon waitrequest
    input wire logic psc_tick_i,        // Prescaler clock tick
    input wire logic event_pin_a_i,     // Counter A event pin
    input wire logic event_pin_b_i,     // Counter B event pin
    input wire logic comparator_debounced_out_i, // Comparator level
    input wire logic comparator_pulse_event_i,   // Comparator pulse
    output logic irq_o                  // Interrupt, active high
);

    evc_pkg::top_state_t st_r;   // Registered state
    evc_pkg::top_state_t st_nxt; // Next state
    logic [1:0] pins_sync;       // Synchronised event pins
    logic src_a;                 // Counter A selected source
    logic src_b;                 // Counter B selected source
    logic [7:0] count_a;         // Counter A value
    logic [7:0] count_b;         // Counter B value
    logic ovf_a;                 // Counter A overflow pulse
    logic ovf_b;                 // Counter B overflow pulse
    logic take;                  // Bus access completes this edge
    logic wr_lane;               // Write touching the low byte
    logic load_a;                // Preload A write strobe
    logic load_b;                // Preload B write strobe
    logic [1:0] clr;             // Status bits to clear
    logic [1:0] ev;              // Overflow events
    logic [31:0] rmux;           // Read data selection

    // Event pins come from outside and are synchronised first
    evc_sync2 u_sync (
        .clk_sys_i (clk_sys_i),
        .rstn_i (rstn_i),
        .async_i ({event_pin_b_i, event_pin_a_i}),
        .sync_o (pins_sync)
    );

    // Source selection for both counters
    always_comb
    begin
        if (st_r.ctrl_a[`EVC_SRC_BIT])
        begin
            src_a = comparator_debounced_out_i;
        end
        else
        begin
            src_a = pins_sync[0];
        end
        if (st_r.ctrl_b[`EVC_SRC_BIT])
        begin
            src_b = comparator_pulse_event_i;
        end
        else
        begin
            src_b = pins_sync[1];
        end
    end

    // Counter A channel
    evc_core u_core_a (
        .clk_sys_i (clk_sys_i),
        .rstn_i (rstn_i),
        .mode_i (st_r.ctrl_a[`EVC_MODE_HI:`EVC_MODE_LO]),
        .run_i (st_r.ctrl_a[`EVC_RUN_BIT]),
        .edge_i (st_r.ctrl_a[`EVC_EDGE_BIT]),
        .div_i (st_r.ctrl_a[`EVC_DIV_HI:`EVC_DIV_LO]),
        .pulse_src_i (1'b0),
        .src_i (src_a),
        .psc_tick_i (psc_tick_i),
        .preload_i (st_r.pre_a),
        .load_i (load_a),
        .load_val_i (writedata_i[7:0]),
        .count_o (count_a),
        .ovf_o (ovf_a)
    );

    // Counter B channel; comparator pulse source counts every pulse
    evc_core u_core_b (
        .clk_sys_i (clk_sys_i),
        .rstn_i (rstn_i),
        .mode_i (st_r.ctrl_b[`EVC_MODE_HI:`EVC_MODE_LO]),
        .run_i (st_r.ctrl_b[`EVC_RUN_BIT]),
        .edge_i (st_r.ctrl_b[`EVC_EDGE_BIT]),
        .div_i (st_r.ctrl_b[`EVC_DIV_HI:`EVC_DIV_LO]),
        .pulse_src_i (st_r.ctrl_b[`EVC_SRC_BIT]),
        .src_i (src_b),
        .psc_tick_i (psc_tick_i),
        .preload_i (st_r.pre_b),
        .load_i (load_b),
        .load_val_i (writedata_i[7:0]),
        .count_o (count_b),
        .ovf_o (ovf_b)
    );

    // Read data selection; data offsets read the live count
    always_comb
    begin
        rmux = `EVC_RDATA_RST;
        case (address_i)
            `EVC_OFF_CTRL_A: rmux[7:0] = st_r.ctrl_a;
            `EVC_OFF_CTRL_B: rmux[7:0] = st_r.ctrl_b;
            `EVC_OFF_DATA_A: rmux[7:0] = count_a;
            `EVC_OFF_DATA_B: rmux[7:0] = count_b;
            `EVC_OFF_STATUS: rmux[1:0] = st_r.status;
            `EVC_OFF_MASK: rmux[1:0] = st_r.mask;
            // Unmapped offsets read zero
            default: rmux = `EVC_RDATA_RST;
        endcase
    end

    // Bus slave, register writes and interrupt status
    always_comb
    begin
        st_nxt = st_r;
        take = (read_i | write_i) & ~st_r.waitreq;
        wr_lane = take & write_i & byteenable_i[0];
        load_a = wr_lane && address_i == `EVC_OFF_DATA_A;
        load_b = wr_lane && address_i == `EVC_OFF_DATA_B;
        clr = 2'h0;
        ev = {ovf_b, ovf_a};
        // One wait cycle, then the access completes
        if ((read_i || write_i) && st_r.waitreq)
        begin
            st_nxt.waitreq = 1'b0;
            st_nxt.rdata = rmux;
        end
        else
        begin
            st_nxt.waitreq = 1'b1;
        end
        // Register writes on the low byte lane
        if (wr_lane)
        begin
            case (address_i)
                `EVC_OFF_CTRL_A: st_nxt.ctrl_a = writedata_i[7:0];
                `EVC_OFF_CTRL_B: st_nxt.ctrl_b = writedata_i[7:0];
                // Preload always stored, used at next overflow
                `EVC_OFF_DATA_A: st_nxt.pre_a = writedata_i[7:0];
                `EVC_OFF_DATA_B: st_nxt.pre_b = writedata_i[7:0];
                `EVC_OFF_STATUS: clr = writedata_i[1:0];
                `EVC_OFF_MASK: st_nxt.mask = writedata_i[1:0];
                // Unmapped writes are dropped
                default: clr = 2'h0;
            endcase
        end
        // New overflow wins over a clear in the same cycle
        st_nxt.status = (st_r.status & ~clr) | ev;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    // Register the state
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            st_r.ctrl_a <= `EVC_CTRL_RST;
            st_r.ctrl_b <= `EVC_CTRL_RST;
            st_r.pre_a <= `EVC_PRE_RST;
            st_r.pre_b <= `EVC_PRE_RST;
            st_r.status <= `EVC_IRQ_RST;
            st_r.mask <= `EVC_IRQ_RST;
            st_r.waitreq <= 1'b1;
            st_r.rdata <= `EVC_RDATA_RST;
            st_r.irq <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign readdata_o = st_r.rdata;
    assign waitrequest_o = st_r.waitreq;
    assign irq_o = st_r.irq;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // Selected source follows the select bit
    a_src_a_select: assert property (
        st_r.ctrl_a[`EVC_SRC_BIT] |-> src_a == comparator_debounced_out_i)
        else $error("counter A source wrong");
    a_src_b_select: assert property (
        st_r.ctrl_b[`EVC_SRC_BIT] |-> src_b == comparator_pulse_event_i)
        else $error("counter B source wrong");
    // Running preload write leaves the count alone between ticks
    a_running_preload: assert property (
        load_a && st_r.ctrl_a[`EVC_RUN_BIT] && !psc_tick_i
        && st_r.ctrl_a[`EVC_MODE_HI:`EVC_MODE_LO] == 2'h2
        |=> $stable(count_a))
        else $error("running preload changed count");
    // Unmasked overflow raises the interrupt next cycle
    a_irq_overflow: assert property (
        ((ovf_a && st_r.mask[`EVC_IRQ_A_BIT])
        || (ovf_b && st_r.mask[`EVC_IRQ_B_BIT]))
        && !(wr_lane && address_i == `EVC_OFF_MASK) |=> irq_o)
        else $error("overflow did not interrupt");
    // Every request is answered after one wait cycle
    a_bus_answer: assert property (
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("waitrequest not released");

    c_read_done: cover property (take && read_i);
    c_irq_seen: cover property (irq_o);
    c_ovf_b: cover property (ovf_b && st_r.ctrl_b[`EVC_SRC_BIT]);

endmodule : event_counter_control

// ---- dv/evc_partner.sv ----
module evc_partner (
    input wire logic clk_sys_i,  // System clock
    output logic psc_tick_o,     // Prescaler clock tick
    output logic event_pin_a_o,  // Counter A event pin
    output logic event_pin_b_o,  // Counter B event pin
    output logic cmp_level_o,    // Comparator debounced level
    output logic cmp_pulse_o     // Comparator high pulse
);
    timeunit 1ns;
    timeprecision 1ns;

    // All lines quiet from time zero
    initial
    begin
        psc_tick_o = 1'b0;
        event_pin_a_o = 1'b0;
        event_pin_b_o = 1'b0;
        cmp_level_o = 1'b0;
        cmp_pulse_o = 1'b0;
    end

    // Back-to-back ticks, then time for the last count to land
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge clk_sys_i);
            psc_tick_o <= 1'b1;
        end
        @(posedge clk_sys_i);
        psc_tick_o <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask : ticks

    // Level change on one line, then wait out sync and edge logic
    task automatic set_line(input int which, input logic v);
        @(posedge clk_sys_i);
        case (which)
            0: event_pin_a_o <= v;
            1: cmp_level_o <= v;
            default: event_pin_b_o <= v;
        endcase
        repeat (6) @(posedge clk_sys_i);
    endtask : set_line

    // One-cycle high pulse, as the comparator gives it
    task automatic pulse_cmp();
        @(posedge clk_sys_i);
        cmp_pulse_o <= 1'b1;
        @(posedge clk_sys_i);
        cmp_pulse_o <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask : pulse_cmp
endmodule : evc_partner

// ---- dv/tb_top.sv ----
`include "evc_map.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys_i = 1'b0;  // 10 MHz clock
    logic rstn_i = 1'b0;  // Reset, active low
    logic [7:0] address_i;  // Bus address
    logic read_i;  // Bus read
    logic write_i;  // Bus write
    logic [31:0] writedata_i;  // Bus write data
    logic [3:0] byteenable_i;  // Bus byte enables
    logic [31:0] readdata_o;  // Bus read data
    logic waitrequest_o;  // Bus wait
    logic psc_tick;  // Prescaler tick from the model
    logic pin_a, pin_b, cmp_lvl, cmp_pls;  // Model lines
    logic irq_o;  // Interrupt
    int mismatches = 0;  // Failed comparisons
    int cmp_count = 0;  // All comparisons

    // Clock generator
    always #50 clk_sys_i = ~clk_sys_i;

    event_counter_control i_event_counter_control (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .psc_tick_i(psc_tick),
        .event_pin_a_i(pin_a), .event_pin_b_i(pin_b),
        .comparator_debounced_out_i(cmp_lvl),
        .comparator_pulse_event_i(cmp_pls), .irq_o(irq_o));

    evc_partner i_evc_partner (
        .clk_sys_i(clk_sys_i), .psc_tick_o(psc_tick),
        .event_pin_a_o(pin_a), .event_pin_b_o(pin_b),
        .cmp_level_o(cmp_lvl), .cmp_pulse_o(cmp_pls));

    // Verdict and end of run
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // Compare one value, report and count a difference
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        @(posedge clk_sys_i);
        address_i <= a;
        writedata_i <= d;
        byteenable_i <= be;
        read_i <= !wr;
        write_i <= wr;
        n = 0;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (waitrequest_o !== 1'b0 && n < 20);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        if (waitrequest_o !== 1'b0)
        begin
            mismatches++;
            test_done();
        end
    endtask : bus

    // Full-word write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask : wr

    // Read and compare
    task automatic rc(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hf, q);
        chk(what, q, exp);
    endtask : rc

    // Let the registered interrupt settle, then compare it
    task automatic chk_irq(input logic exp);
        repeat (3) @(posedge clk_sys_i);
        chk("irq", {31'h0, irq_o}, {31'h0, exp});
    endtask : chk_irq

    // Stop, clear the count, then write the full control value
    task automatic cfg(input logic [7:0] ctl_off, input logic [7:0] ctl);
        wr(ctl_off, {24'h0, ctl & 8'hef});
        wr(ctl_off + 8'h08, 32'h0000_0000);
        wr(ctl_off, {24'h0, ctl});
    endtask : cfg

    // Reset values of every register except data B, and the interrupt
    task automatic t_reset();
        rc(`EVC_OFF_CTRL_A, 32'h0000_0008, "ctrl a reset");
        rc(`EVC_OFF_CTRL_B, 32'h0000_0008, "ctrl b reset");
        rc(`EVC_OFF_DATA_A, 32'h0000_0000, "count a reset");
        rc(`EVC_OFF_STATUS, 32'h0000_0000, "status reset");
        rc(`EVC_OFF_MASK, 32'h0000_0000, "mask reset");
        chk_irq(1'b0);
    endtask : t_reset

    // Timer mode over every divider code, run bit and mode 00
    task automatic t_timer();
        int d;
        for (d = 0; d < 8; d++)
        begin
            cfg(`EVC_OFF_CTRL_A, 8'h90 | d[7:0]);
            i_evc_partner.ticks(2 << d);
            rc(`EVC_OFF_DATA_A, 32'h0000_0002, "timer count");
        end
        wr(`EVC_OFF_CTRL_A, 32'h0000_0087);
        i_evc_partner.ticks(8);
        rc(`EVC_OFF_DATA_A, 32'h0000_0002, "stopped count");
        cfg(`EVC_OFF_CTRL_A, 8'h10);
        i_evc_partner.ticks(4);
        rc(`EVC_OFF_DATA_A, 32'h0000_0000, "mode none");
        cfg(`EVC_OFF_CTRL_B, 8'h91);
        i_evc_partner.ticks(4);
        rc(`EVC_OFF_DATA_B, 32'h0000_0002, "b timer");
    endtask : t_timer

    // Event mode: both sources and both edges, then counter B sources
    task automatic t_event();
        int s;
        int e;
        for (s = 0; s < 2; s++)
            for (e = 0; e < 2; e++)
            begin
                cfg(`EVC_OFF_CTRL_A, 8'h57 | 8'(s << 5) | 8'(e << 3));
                i_evc_partner.set_line(s, 1'b1);
                rc(`EVC_OFF_DATA_A, (e == 0), "rise");
                i_evc_partner.set_line(s, 1'b0);
                rc(`EVC_OFF_DATA_A, 32'h0000_0001, "fall");
            end
        // Counter B event mode: pulse source counts pulses, ignores the pin; pin source ignores pulses
        cfg(`EVC_OFF_CTRL_B, 8'h78);
        repeat (3) i_evc_partner.pulse_cmp();
        i_evc_partner.set_line(2, 1'b1);
        i_evc_partner.set_line(2, 1'b0);
        rc(`EVC_OFF_DATA_B, 32'h0000_0003, "b pulses");
        cfg(`EVC_OFF_CTRL_B, 8'h50);
        i_evc_partner.pulse_cmp();
        i_evc_partner.set_line(2, 1'b1);
        rc(`EVC_OFF_DATA_B, 32'h0000_0001, "b pin");
        i_evc_partner.set_line(2, 1'b0);
    endtask : t_event

    // Width mode: ticks count only between start and stop edges
    task automatic t_width();
        int e;
        for (e = 1; e >= 0; e--)
        begin
            i_evc_partner.set_line(0, e == 0);
            cfg(`EVC_OFF_CTRL_A, 8'hd0 | 8'(e << 3));
            i_evc_partner.ticks(5);
            rc(`EVC_OFF_DATA_A, 32'h0000_0000, "width idle");
            i_evc_partner.set_line(0, e != 0);
            i_evc_partner.ticks(7);
            rc(`EVC_OFF_DATA_A, 32'h0000_0007, "width open");
            i_evc_partner.set_line(0, e == 0);
            i_evc_partner.ticks(5);
            rc(`EVC_OFF_DATA_A, 32'h0000_0007, "width shut");
        end
        i_evc_partner.set_line(0, 1'b0);
    endtask : t_width

    // Overflow, reload, preload timing, interrupt and odd accesses
    task automatic t_ovf();
        logic [31:0] q;
        wr(`EVC_OFF_MASK, 32'h0000_0001);
        wr(`EVC_OFF_CTRL_A, 32'h0000_0080);
        wr(`EVC_OFF_DATA_A, 32'h0000_00fd);
        rc(`EVC_OFF_DATA_A, 32'h0000_00fd, "stopped load");
        wr(`EVC_OFF_CTRL_A, 32'h0000_0090);
        i_evc_partner.ticks(2);
        rc(`EVC_OFF_DATA_A, 32'h0000_00ff, "full count");
        chk_irq(1'b0);
        i_evc_partner.ticks(1);
        rc(`EVC_OFF_DATA_A, 32'h0000_00fd, "reload");
        rc(`EVC_OFF_STATUS, 32'h0000_0001, "ovf flag");
        chk_irq(1'b1);
        wr(`EVC_OFF_DATA_A, 32'h0000_0010);
        rc(`EVC_OFF_DATA_A, 32'h0000_00fd, "running load");
        i_evc_partner.ticks(3);
        rc(`EVC_OFF_DATA_A, 32'h0000_0010, "new reload");
        bus(1'b1, `EVC_OFF_STATUS, 32'h0000_0001, 4'h0, q);
        rc(`EVC_OFF_STATUS, 32'h0000_0001, "no byte enable");
        wr(`EVC_OFF_MASK, 32'h0000_0000);
        chk_irq(1'b0);
        wr(`EVC_OFF_MASK, 32'h0000_0001);
        chk_irq(1'b1);
        wr(`EVC_OFF_STATUS, 32'h0000_0001);
        rc(`EVC_OFF_STATUS, 32'h0000_0000, "status clear");
        chk_irq(1'b0);
        wr(8'h18, 32'h0000_00ff);
        rc(8'h18, 32'h0000_0000, "unmapped");
    endtask : t_ovf

    // Main sequence; bus lines idle until the first task drives them
    initial
    begin
        address_i <= 8'h00;
        read_i <= 1'b0;
        write_i <= 1'b0;
        writedata_i <= 32'h0000_0000;
        byteenable_i <= 4'h0;
        repeat (12) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_reset();
        t_timer();
        t_event();
        t_width();
        t_ovf();
        test_done();
    end
endmodule : tb_top
